// *** rtl/pabcs_pkg.sv ***
// Purpose: Shared constants and types for the PCI arbiter config/status block
// Assumes: Configuration accesses arrive as byte-addressed 8-bit cycles
// Notes: Offsets are configuration-space byte addresses
package pabcs_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG_LO = 8'h50;
  localparam logic [7:0] ADDR_CONFIG_HI = 8'h51;
  localparam logic [7:0] ADDR_SLICE = 8'h70;
  localparam logic [7:0] ADDR_STATUS = 8'h82;
  localparam logic [15:0] CONFIG_RESET = 16'h1400;
  localparam logic [7:0] SLICE_RESET = 8'h20;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Writable bits of the config register (bits 9, 8, 1)
  localparam logic [15:0] CONFIG_WMASK = 16'h0302;
  localparam int BIT_PRIO = 9;
  localparam int BIT_HOLE = 8;
  localparam int BIT_RETRY = 1;
  localparam logic [7:0] SLICE_WMASK = 8'hF8;
  localparam int BIT_INT_REQ = 7;
  localparam int BIT_LAN_REQ = 6;
  // ----------------------------------------------------------------------
  // Arbiter sizing and timing
  // ----------------------------------------------------------------------
  localparam int NUM_REQ = 8;
  localparam int NUM_EXT = 6;
  localparam int SLICE_UNIT_CLKS = 8;
  localparam logic [3:0] LOCK_RETRY_CLKS = 4'd12;
  // Hole: 15 MB up to 16 MB
  localparam logic [31:0] HOLE_BASE = 32'h00F0_0000;
  localparam logic [31:0] HOLE_LIMIT = 32'h0100_0000;

  typedef enum logic [1:0] {ARB_IDLE, ARB_OWNED} pabcs_arb_state_t;
endpackage : pabcs_pkg

// *** rtl/pabcs_req_if.sv ***
// Purpose: Carries request vector and the active grant between modules
// Assumes: One grant at a time
// Notes: Index 0..5 external, 6 LAN, 7 internal DMA/LPC
`timescale 1ns/1ps
interface pabcs_req_if;
  logic [7:0] reqVec;
  logic [7:0] grantVec;
  logic prioEnable;
  modport arb (input reqVec, input prioEnable, output grantVec);
  modport top (output reqVec, output prioEnable, input grantVec);
endinterface : pabcs_req_if

// *** rtl/pabcs_arb_core.sv ***
// Purpose: Round-robin grant chooser with optional priority for pair 0
// Assumes: Requests active high, synchronous
// Notes: Purely combinational pick; the top registers the grant
`timescale 1ns/1ps
module pabcs_arb_core (
  pabcs_req_if.arb bus,
  input wire logic [2:0] lastOwner
);
  import pabcs_pkg::*;
  // ----------------------------------------------------------------------
  // Pick next requester after the last owner
  // ----------------------------------------------------------------------
  always_comb begin
    logic found;
    logic [2:0] idx;
    found = 1'b0;
    idx = 3'd0;
    bus.grantVec = 8'h00;
    if (bus.prioEnable && bus.reqVec[0]) begin
      bus.grantVec = 8'h01; // Pair 0 first
    end else begin
      for (int k = 1; k <= NUM_REQ; k++) begin
        idx = 3'(lastOwner + 3'(k)); // Equal rotation
        if (!found && bus.reqVec[idx]) begin
          found = 1'b1;
          bus.grantVec = 8'h01 << idx;
        end
      end
    end
  end
endmodule : pabcs_arb_core

// *** rtl/pabcs_top.sv ***
// Purpose: PCI arbiter configuration, slice timer and request status flags
// Assumes: Byte-wide config accesses, PCI-clock synchronous request inputs
// Notes: Grant changes only at idle, when the owner drops its request, or when the slice timer expires
`timescale 1ns/1ps
module pabcs_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgWdata,
  output logic [7:0] cfgRdata,
  input wire logic [pabcs_pkg::NUM_EXT-1:0] extReq,
  input wire logic lanReq,
  input wire logic intReq,
  input wire logic lockedCycle,
  input wire logic othersWaitLock,
  input wire logic [31:0] memAddr,
  output logic [pabcs_pkg::NUM_REQ-1:0] grant,
  output logic lockRetry,
  output logic inHole
);
  import pabcs_pkg::*;

  typedef struct packed {
    logic [15:0] arbCfg;
    logic [7:0] slice;
    logic [7:0] status;
    logic [7:0] grant;
    logic [2:0] owner;
    logic [10:0] sliceCnt;
    logic [3:0] lockCnt;
    logic [3:0] lockRun;
    logic lockRetry;
    logic inHole;
    logic [7:0] rdata;
    pabcs_arb_state_t state;
  } pabcs_state_t;

  pabcs_state_t st_r;
  pabcs_state_t st_nxt;
  logic [7:0] reqAll;
  logic [10:0] sliceLimit;
  logic sliceOn;
  logic sliceDone;

  pabcs_req_if reqBus ();
  // ----------------------------------------------------------------------
  // Arbitration choice
  // ----------------------------------------------------------------------
  assign reqAll = {intReq, lanReq, extReq};
  assign reqBus.reqVec = reqAll;
  assign reqBus.prioEnable = st_r.arbCfg[BIT_PRIO];

  pabcs_arb_core uArb (
    .bus(reqBus.arb),
    .lastOwner(st_r.owner)
  );

  // Count field in eight-clock units; reserved low bits never counted
  assign sliceLimit = 11'(st_r.slice[7:3]) * 11'(SLICE_UNIT_CLKS);
  assign sliceOn = (st_r.slice[7:3] != 5'd0); // Zero means no limit
  // Below 16 clocks this fires ahead of the frame latency trigger
  assign sliceDone = sliceOn && (st_r.sliceCnt + 11'd1 >= sliceLimit);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [7:0] clr;
    st_nxt = st_r;
    clr = 8'h00;
    // Config writes; reserved bits stay at reset value
    if (cfgWrite) begin
      unique case (cfgAddr)
        ADDR_CONFIG_LO: st_nxt.arbCfg[7:0] = (st_r.arbCfg[7:0] & ~CONFIG_WMASK[7:0])
                                             | (cfgWdata & CONFIG_WMASK[7:0]);
        ADDR_CONFIG_HI: st_nxt.arbCfg[15:8] = (st_r.arbCfg[15:8] & ~CONFIG_WMASK[15:8])
                                              | (cfgWdata & CONFIG_WMASK[15:8]);
        ADDR_SLICE: st_nxt.slice = cfgWdata & SLICE_WMASK;
        ADDR_STATUS: clr = cfgWdata; // Ones clear, zeros ignored
        default: ;
      endcase
    end
    // New requests applied after clear so a set wins
    st_nxt.status = (st_r.status & ~clr) | reqAll;

    // Read mux registered so data leaves a flop
    unique case (cfgAddr)
      ADDR_CONFIG_LO: st_nxt.rdata = st_r.arbCfg[7:0];
      ADDR_CONFIG_HI: st_nxt.rdata = st_r.arbCfg[15:8];
      ADDR_SLICE: st_nxt.rdata = st_r.slice;
      ADDR_STATUS: st_nxt.rdata = st_r.status;
      default: st_nxt.rdata = 8'h00;
    endcase
    if (!cfgRead) st_nxt.rdata = st_r.rdata;

    // Grant and time slice
    unique case (st_r.state)
      ARB_IDLE: begin
        st_nxt.sliceCnt = 11'd0;
        if (reqBus.grantVec != 8'h00) begin
          st_nxt.grant = reqBus.grantVec;
          for (int i = 0; i < NUM_REQ; i++) begin
            if (reqBus.grantVec[i]) st_nxt.owner = 3'(i);
          end
          st_nxt.state = ARB_OWNED;
        end
      end
      ARB_OWNED: begin
        st_nxt.sliceCnt = st_r.sliceCnt + 11'd1;
        // Owner dropped request or slice expired: rearbitrate
        if (!reqAll[st_r.owner] || sliceDone) begin
          st_nxt.grant = 8'h00;
          st_nxt.state = ARB_IDLE;
        end
      end
    endcase

    // Locked-cycle retry counter, active only when software enabled it
    st_nxt.lockRetry = 1'b0;
    if (st_r.arbCfg[BIT_RETRY] && lockedCycle && othersWaitLock) begin
      st_nxt.lockCnt = st_r.lockCnt + 4'd1;
      if (st_r.lockCnt == LOCK_RETRY_CLKS - 4'd1) begin
        st_nxt.lockRetry = 1'b1;
        st_nxt.lockCnt = 4'd0;
      end
    end else begin
      st_nxt.lockCnt = 4'd0; // Disabled: lock never broken
    end

    // Saturating run length of the retry condition; only the checks read it,
    // so a broken retry counter cannot hide behind its own value
    if (st_r.arbCfg[BIT_RETRY] && lockedCycle && othersWaitLock) begin
      st_nxt.lockRun = (st_r.lockRun == 4'hF) ? 4'hF : st_r.lockRun + 4'h1;
    end else begin
      st_nxt.lockRun = 4'h0;
    end

    // Memory hole decode
    st_nxt.inHole = st_r.arbCfg[BIT_HOLE] && (memAddr >= HOLE_BASE)
                    && (memAddr < HOLE_LIMIT);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '{arbCfg: CONFIG_RESET, slice: SLICE_RESET, status: STATUS_RESET,
                grant: 8'h00, owner: 3'd0, sliceCnt: 11'd0, lockCnt: 4'd0, lockRun: 4'h0,
                lockRetry: 1'b0, inHole: 1'b0, rdata: 8'h00,
                state: ARB_IDLE};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfgRdata = st_r.rdata;
  assign grant = st_r.grant;
  assign lockRetry = st_r.lockRetry;
  assign inHole = st_r.inHole;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_slice_reset: assert property (@(posedge clk)
    $rose(rst_b) |-> st_r.slice == 8'h20)
    else $error("slice timer not 20h after reset");
  a_status_set: assert property (@(posedge clk) disable iff (!rst_b)
    reqAll[0] |=> st_r.status[0])
    else $error("external request flag not set");
  a_int_set: assert property (@(posedge clk) disable iff (!rst_b)
    intReq |=> st_r.status[7])
    else $error("internal request flag not set");
  a_lan_set: assert property (@(posedge clk) disable iff (!rst_b)
    lanReq |=> st_r.status[6])
    else $error("lan request flag not set");
  a_status_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.status[1] && !(cfgWrite && cfgAddr == ADDR_STATUS && cfgWdata[1])
    |=> st_r.status[1])
    else $error("status flag dropped without write one");
  a_set_wins: assert property (@(posedge clk) disable iff (!rst_b)
    cfgWrite && cfgAddr == ADDR_STATUS && cfgWdata[2] && reqAll[2] |=> st_r.status[2])
    else $error("request lost on clear");
  // Twelfth consecutive cycle of the condition, counted by the run length
  a_retry_twelve: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.arbCfg[BIT_RETRY] && lockedCycle && othersWaitLock
    && st_r.lockRun == LOCK_RETRY_CLKS - 4'h1 |=> lockRetry)
    else $error("locked retry not after 12 clocks");
  a_retry_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    lockRetry |=> !lockRetry)
    else $error("locked retry longer than one clock");
  a_no_retry: assert property (@(posedge clk) disable iff (!rst_b)
    !st_r.arbCfg[BIT_RETRY] |=> !lockRetry)
    else $error("retry while disabled");
  a_prio_pair: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.state == ARB_IDLE && st_r.arbCfg[BIT_PRIO] && reqAll[0] |=> grant == 8'h01)
    else $error("pair 0 not preferred");
  a_no_limit: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.slice[7:3] == 5'd0 && st_r.state == ARB_OWNED && reqAll[st_r.owner]
    |=> st_r.state == ARB_OWNED)
    else $error("grant removed with slice disabled");
  a_slice_expire: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.slice[7:3] != 5'd0 && st_r.state == ARB_OWNED
    && st_r.sliceCnt == 11'(st_r.slice[7:3]) * 11'd8 - 11'd1 |=> grant == 8'h00)
    else $error("grant held past its slice");
  a_grant_onehot: assert property (@(posedge clk) disable iff (!rst_b)
    $onehot0(grant))
    else $error("more than one grant at once");
  a_hole_off: assert property (@(posedge clk) disable iff (!rst_b)
    !st_r.arbCfg[BIT_HOLE] |=> !inHole)
    else $error("hole decoded while disabled");
endmodule : pabcs_top

// *** test/pabcs_master_model.sv ***
// Purpose: Behavioural external bus masters facing the arbiter
// Assumes: Grant is one-hot and registered by the arbiter
// Notes: A master drops its request after burstLen granted cycles
`timescale 1ns/1ps
module pabcs_master_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [5:0] want,
  input wire logic [7:0] burstLen,
  input wire logic [5:0] grantIn,
  output logic [5:0] extReq
);
  logic [7:0] usedCnt [6];
  // Request while wanted; stay off while still granted once the burst is spent
  always_ff @(posedge clk or negedge rst_b) begin
    for (int i = 0; i < 6; i++) begin
      if (!rst_b) begin
        usedCnt[i] <= 8'h00;
        extReq[i] <= 1'b0;
      end else begin
        usedCnt[i] <= grantIn[i] ? usedCnt[i] + 8'h01 : 8'h00;
        extReq[i] <= want[i] && !(grantIn[i] && {1'b0, usedCnt[i]} + 9'h001 >= {1'b0, burstLen});
      end
    end
  end
endmodule : pabcs_master_model

// *** test/testbench.sv ***
// Purpose: Self-checking bench for the arbiter config and status block
// Assumes: Inputs change at the falling edge only
// Notes: Random status patterns come from a fixed seed
`timescale 1ns/1ps
module testbench;
  import pabcs_pkg::*;
  logic clk, rst_b, cfgWrite, cfgRead, lanReq, intReq, lockedCycle, othersWaitLock;
  logic [7:0] cfgAddr, cfgWdata, cfgRdata, grant, rd, burstLen;
  logic [5:0] extReq, want;
  logic [31:0] memAddr, r;
  logic lockRetry, inHole;
  int errCount, samplesChecked, n;
  logic [31:0] holeAddr [4] = '{32'h00EF_FFFF, HOLE_BASE, 32'h00FF_FFFF, HOLE_LIMIT};
  logic [7:0] slices [5] = '{8'h08, 8'h18, 8'h20, 8'h0F, 8'h00};
  pabcs_top pabcs_top_i (.clk(clk), .rst_b(rst_b), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
    .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .extReq(extReq),
    .lanReq(lanReq), .intReq(intReq), .lockedCycle(lockedCycle),
    .othersWaitLock(othersWaitLock), .memAddr(memAddr), .grant(grant),
    .lockRetry(lockRetry), .inHole(inHole));
  pabcs_master_model pabcs_master_model_i (.clk(clk), .rst_b(rst_b), .want(want),
    .burstLen(burstLen), .grantIn(grant[5:0]), .extReq(extReq));
  // ----------------------------------------
  // Clock and shared tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  task automatic timeout;
    errCount++;
    $display("[ERR] wait expected done seen timeout");
    print_verdict();
  endtask : timeout
  // Strobe drops for one edge, so back-to-back calls never merge
  task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cfgAddr = a;
    cfgWdata = d;
    cfgWrite = 1'b1;
    @(negedge clk);
    cfgWrite = 1'b0;
  endtask : cfg_wr
  task automatic rd_check(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    cfgAddr = a;
    cfgRead = 1'b1;
    @(negedge clk);
    cfgRead = 1'b0;
    check(what, cfgRdata, exp);
  endtask : rd_check
  task automatic wait_grant;
    n = 0;
    while (grant === 8'h00) begin
      @(negedge clk);
      n++;
      if (n > 400) timeout();
    end
  endtask : wait_grant
  // Two greedy masters; the slice alone ends the first tenure
  task automatic slice_run(input logic [7:0] s);
    cfg_wr(ADDR_SLICE, s);
    rd_check("slice rd", ADDR_SLICE, s & SLICE_WMASK);
    want = 6'h03;
    wait_grant();
    rd = grant;
    n = 0;
    // No limit: stop watching once the tenure clearly outlives every slice the bench tests
    while (grant === rd && !(s[7:3] == 5'h00 && n > 200)) begin
      @(negedge clk);
      n++;
      if (n > 600) timeout();
    end
    if (s[7:3] == 5'h00) begin
      check("no limit", n > 200, 1);
    end else begin
      check("slice len", n, s[7:3] * 8);
      wait_grant();
      check("next owner", grant !== rd && grant !== 8'h00, 1);
    end
    want = 6'h00;
    repeat (4) @(negedge clk);
  endtask : slice_run
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(67536));
    {rst_b, cfgWrite, cfgRead, lanReq, intReq, lockedCycle, othersWaitLock} = 7'h00;
    {cfgAddr, cfgWdata, memAddr, want, errCount, samplesChecked} = '0;
    burstLen = 8'hFF;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    rd_check("cfg lo", ADDR_CONFIG_LO, CONFIG_RESET[7:0]);
    rd_check("cfg hi", ADDR_CONFIG_HI, CONFIG_RESET[15:8]);
    rd_check("slice", ADDR_SLICE, SLICE_RESET);
    rd_check("status", ADDR_STATUS, STATUS_RESET);
    rd_check("unmapped", 8'h60, 8'h00);
    cfg_wr(ADDR_CONFIG_LO, 8'hFF);
    cfg_wr(ADDR_CONFIG_HI, 8'hFF);
    rd_check("cfg lo w", ADDR_CONFIG_LO, 8'h02);
    rd_check("cfg hi w", ADDR_CONFIG_HI, 8'h17);
    // Hole edges, with the window off and on
    for (int e = 0; e < 2; e++) begin
      cfg_wr(ADDR_CONFIG_HI, e[7:0]);
      for (int k = 0; k < 4; k++) begin
        @(negedge clk);
        memAddr = holeAddr[k];
        @(negedge clk);
        check("hole", inHole, e == 1 && k inside {1, 2});
      end
    end
    // Locked cycle retry on, then off
    cfg_wr(ADDR_CONFIG_LO, 8'h02);
    lockedCycle = 1'b1;
    othersWaitLock = 1'b1;
    n = 0;
    while (lockRetry !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 40) timeout();
    end
    check("retry gap", n, 12);
    @(negedge clk);
    check("retry pulse", lockRetry, 0);
    cfg_wr(ADDR_CONFIG_LO, 8'h00);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      n += int'(lockRetry);
    end
    check("no retry", n, 0);
    {lockedCycle, othersWaitLock} = 2'b00;
    // Sticky flags from random request patterns
    cfg_wr(ADDR_STATUS, 8'hFF);
    repeat (8) begin
      r = $urandom;
      @(negedge clk);
      {intReq, lanReq, want} = r[7:0];
      repeat (3) @(negedge clk);
      {intReq, lanReq, want} = 8'h00;
      repeat (3) @(negedge clk);
      rd_check("status set", ADDR_STATUS, r[7:0]);
      cfg_wr(ADDR_STATUS, r[15:8]);
      rd_check("status clr", ADDR_STATUS, r[7:0] & ~r[15:8]);
      cfg_wr(ADDR_STATUS, 8'hFF);
    end
    // Request lands on the very edge of the clearing write
    @(negedge clk);
    {intReq, cfgWrite, cfgAddr, cfgWdata} = {2'b11, ADDR_STATUS, 8'h80};
    @(negedge clk);
    {intReq, cfgWrite} = 2'b00;
    rd_check("set wins", ADDR_STATUS, 8'h80);
    foreach (slices[i]) slice_run(slices[i]);
    // Pair 0 just owned the bus; only priority lets it win again
    burstLen = 8'h04;
    for (int p = 0; p < 2; p++) begin
      cfg_wr(ADDR_CONFIG_HI, {6'h00, p[0], 1'b0});
      want = 6'h01;
      wait_grant();
      want = 6'h00;
      repeat (8) @(negedge clk);
      want = 6'h3F;
      wait_grant();
      check("prio", grant[0], p == 1);
      want = 6'h00;
      repeat (8) @(negedge clk);
    end
    print_verdict();
  end
endmodule : testbench
